//--- epd_pkg.sv
/*
 * constants, field layout and mode decode for the external port dma channel control block.
 * assumes one 200 MHz clock and a classic wishbone register bus with 32-bit data.
 */
package epd_pkg;

    // ==========================================================
    // channels and register map
    localparam int NCH = 4;
    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_CH6 = 6'h1c;
    localparam logic [5:0] IDX_CH7 = 6'h1d;
    localparam logic [5:0] IDX_CH8 = 6'h1e;
    localparam logic [5:0] IDX_CH9 = 6'h1f;
    localparam logic [5:0] IDX_MASK = 6'h3c;
    localparam int ADR_W = 8;

    // ==========================================================
    // control word fields
    localparam int B_DEN = 0;
    localparam int B_CHAINING_ENABLE = 1;
    localparam int B_TRAN = 2;
    localparam int B_PS_LO = 3;
    localparam int B_KIND = 5;
    localparam int B_PM_LO = 6;
    localparam int B_UPPER = 8;
    localparam int B_MASTER = 9;
    localparam int B_PACED = 10;
    localparam int B_IRQ = 11;
    localparam int B_EXTERN = 12;
    localparam int B_FLUSH = 13;
    localparam int B_FS_LO = 14;
    localparam int CTRL_W = 16;
    localparam logic [15:0] WR_MASK = 16'h1fe7;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] UPPER_ZERO = 16'h0000;

    // ==========================================================
    // field encodings
    localparam logic [1:0] PS_DONE = 2'h0;
    localparam logic [1:0] PS_FIRST = 2'h1;
    localparam logic [1:0] PS_SECOND = 2'h2;
    localparam logic [1:0] PM_NONE = 2'h0;
    localparam logic [1:0] PM_16_32 = 2'h1;
    localparam logic [1:0] PM_16_48 = 2'h2;
    localparam logic [1:0] PM_32_48 = 2'h3;
    localparam logic [1:0] FS_EMPTY = 2'h0;
    localparam logic [1:0] FS_PART = 2'h2;
    localparam logic [1:0] FS_FULL = 2'h3;
    localparam logic [1:0] WW_32 = 2'h0;
    localparam logic [1:0] WW_40 = 2'h1;
    localparam logic [1:0] WW_48 = 2'h2;

    // ==========================================================
    // timing and capability
    localparam int FLUSH_LAT = 2;
    localparam logic [3:0] HS_CH_MASK = 4'h6;

    typedef enum logic [2:0] {
        EPD_SLAVE,
        EPD_REQUEST_PACED,
        EPD_EXT_HS,
        EPD_MASTER,
        EPD_PACED,
        EPD_RSVD
    } epd_mode_t;

    function automatic epd_mode_t epd_decode(input logic m, input logic h, input logic e);
        epd_mode_t r;
        r = EPD_RSVD;
        case ({m, h, e})
            3'h0: r = EPD_SLAVE;
            3'h2: r = EPD_REQUEST_PACED;
            3'h3: r = EPD_EXT_HS;
            3'h4: r = EPD_MASTER;
            3'h6: r = EPD_PACED;
            default: r = EPD_RSVD;
        endcase
        return r;
    endfunction : epd_decode

endpackage : epd_pkg

//--- epd_ch_if.sv
/*
 * per-channel carrier between the register core and its pack and fill trackers.
 * assumes all parties run on the same clock.
 */
`timescale 1ns/1ps
interface epd_ch_if;
    logic [15:0] ctrl;
    logic flush;
    logic ext_word;
    logic fifo_empty;
    logic fifo_full;
    logic [1:0] pack_stage;
    logic [1:0] fill;

    modport core (output ctrl, flush, ext_word, fifo_empty, fifo_full, input pack_stage, fill);
    modport pack (input ctrl, flush, ext_word, output pack_stage);
    modport fillm (input flush, fifo_empty, fifo_full, output fill);
endinterface : epd_ch_if

//--- epd_pack.sv
/*
 * pack stage tracker for one channel.
 * assumes ext_word pulses once per external word moved through the port fifo.
 */
`timescale 1ns/1ps
module epd_pack
    import epd_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // channel carrier
    epd_ch_if.pack ch
);
    typedef struct packed {
        logic [1:0] stage;
    } epd_pack_st_t;

    epd_pack_st_t st_r;
    epd_pack_st_t st_nxt;
    logic [1:0] pm;
    logic [1:0] last;

    assign pm = ch.ctrl[B_PM_LO +: 2];
    // 16/32 needs two words, the 48-bit modes need three
    assign last = (pm == PM_16_32) ? PS_FIRST : PS_SECOND;

    always_comb begin
        st_nxt = st_r;
        if (ch.flush || pm == PM_NONE) begin
            st_nxt.stage = PS_DONE;
        end else if (ch.ext_word) begin
            st_nxt.stage = (st_r.stage == last) ? PS_DONE : st_r.stage + 2'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign ch.pack_stage = st_r.stage;
endmodule : epd_pack

//--- epd_fill.sv
/*
 * buffer fill status encoder for one channel.
 * assumes the port fifo reports empty and full as levels.
 */
`timescale 1ns/1ps
module epd_fill
    import epd_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // channel carrier
    epd_ch_if.fillm ch
);
    typedef struct packed {
        logic [1:0] fs;
    } epd_fill_st_t;

    epd_fill_st_t st_r;
    epd_fill_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (ch.flush) begin
            st_nxt.fs = FS_EMPTY;
        end else if (ch.fifo_full) begin
            st_nxt.fs = FS_FULL;
        end else if (ch.fifo_empty) begin
            st_nxt.fs = FS_EMPTY;
        end else begin
            st_nxt.fs = FS_PART;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign ch.fill = st_r.fs;
endmodule : epd_fill

//--- epd_ctrl.sv
/*
 * external port dma channel control, channels 6 to 9: control registers on wishbone,
 * flush sequencing, mode decode, request and grant generation.
 * assumes a classic wishbone master, one clock, and synchronous fifo status inputs.
 */
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
module epd_ctrl
    import epd_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // boot and system setting
    input wire logic [15:0] boot_ctrl,
    input wire logic internal_word_width,
    // port fifo side, one bit per channel
    input wire logic [NCH-1:0] fifo_empty,
    input wire logic [NCH-1:0] fifo_full,
    input wire logic [NCH-1:0] ext_word,
    input wire logic [NCH-1:0] dma_count_nz,
    output logic [NCH-1:0] fifo_flush,
    output logic [NCH-1:0] mem_fill_req,
    // channel configuration out
    output logic [NCH-1:0] dma_run,
    output logic [NCH-1:0] chain_auto,
    output logic [NCH-1:0] chain_insert,
    output logic [NCH-1:0] dir_tx,
    output logic [2*NCH-1:0] mem_word_sel,
    output logic [2*NCH-1:0] packing_select,
    output logic [NCH-1:0] upper_half_first,
    output logic [NCH-1:0] mode_reserved,
    // requests and interrupts
    output logic [NCH-1:0] per_word_irq,
    output logic [NCH-1:0] slave_req,
    output logic [NCH-1:0] master_xfer,
    output logic [NCH-1:0] strobe_paced,
    output logic [NCH-1:0] ext_to_ext,
    // external handshake pins
    input wire logic [NCH-1:0] dma_request_pin_n,
    output logic [NCH-1:0] dma_grant_pin_n
);

    // ==========================================================
    // state
    typedef struct packed {
        logic [NCH-1:0][15:0] ctrl;
        logic [NCH-1:0] flush_p1;
        logic [NCH-1:0] flush_p2;
        logic boot_pend;
        logic ack;
        logic [31:0] rdata;
        logic [NCH-1:0] run;
        logic [NCH-1:0] c_auto;
        logic [NCH-1:0] c_ins;
        logic [NCH-1:0] tx;
        logic [NCH-1:0][1:0] ww;
        logic [NCH-1:0][1:0] pm;
        logic [NCH-1:0] upper;
        logic [NCH-1:0] rsvd;
        logic [NCH-1:0] irq;
        logic [NCH-1:0] sreq;
        logic [NCH-1:0] mxfer;
        logic [NCH-1:0] paced;
        logic [NCH-1:0] x2x;
        logic [NCH-1:0] grant_n;
        logic [NCH-1:0] fill_req;
    } epd_ctrl_st_t;

    epd_ctrl_st_t st_r;
    epd_ctrl_st_t st_nxt;

    // ==========================================================
    // per-channel trackers
    logic [NCH-1:0][1:0] ps_all;
    logic [NCH-1:0][1:0] fs_all;

    epd_ch_if chif [NCH] ();

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            assign chif[g].ctrl = st_r.ctrl[g];
            assign chif[g].flush = st_r.flush_p2[g];
            assign chif[g].ext_word = ext_word[g];
            assign chif[g].fifo_empty = fifo_empty[g];
            assign chif[g].fifo_full = fifo_full[g];
            assign ps_all[g] = chif[g].pack_stage;
            assign fs_all[g] = chif[g].fill;

            epd_pack u_pack (
                .mclk(mclk),
                .reset(reset),
                .ch(chif[g])
            );

            epd_fill u_fill (
                .mclk(mclk),
                .reset(reset),
                .ch(chif[g])
            );
        end
    endgenerate

    // ==========================================================
    // bus decode
    logic req;
    logic hit;
    logic [1:0] sel_ch;
    logic [15:0] wmask;

    assign req = wb_cyc_i & wb_stb_i;
    // the four control words sit on consecutive indices
    assign hit = (wb_adr_i[ADR_W-1:2] & IDX_MASK) == IDX_CH6;
    assign sel_ch = wb_adr_i[3:2];
    // byte lanes 2 and 3 have no storage
    assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}} & WR_MASK;

    // ==========================================================
    // next state
    always_comb begin
        logic [15:0] c;
        logic [15:0] rd;
        logic rdy;
        logic req_pin;
        epd_mode_t md;
        c = '0;
        rd = '0;
        rdy = 1'b0;
        req_pin = 1'b0;
        md = EPD_RSVD;
        st_nxt = st_r;

        // flush pipeline; one stage per cycle
        st_nxt.flush_p1 = '0;
        st_nxt.flush_p2 = st_r.flush_p1;

        // one wait state: ack rises the cycle after the request, drops after
        st_nxt.ack = req & ~st_r.ack;
        if (req && !st_r.ack) begin
            rd = st_r.ctrl[sel_ch];
            rd[B_FLUSH] = 1'b0;
            rd[B_PS_LO +: 2] = ps_all[sel_ch];
            rd[B_FS_LO +: 2] = fs_all[sel_ch];
            st_nxt.rdata = hit ? {UPPER_ZERO, rd} : 32'h0000_0000;
        end
        // writes land on the edge where the master sees ack
        if (req && st_r.ack && wb_we_i && hit) begin
            st_nxt.ctrl[sel_ch] = (st_r.ctrl[sel_ch] & ~wmask) | (wb_dat_i[15:0] & wmask);
            st_nxt.flush_p1[sel_ch] = wb_dat_i[B_FLUSH] & wb_sel_i[1];
        end

        // channel 6 boot value, taken once after reset
        if (st_r.boot_pend) begin
            st_nxt.ctrl[0] = boot_ctrl & WR_MASK;
            st_nxt.boot_pend = 1'b0;
        end

        for (int i = 0; i < NCH; i++) begin
            c = st_r.ctrl[i];
            md = epd_decode(c[B_MASTER], c[B_PACED], c[B_EXTERN]);
            // rx wants data waiting, tx wants room
            rdy = c[B_TRAN] ? ~fifo_full[i] : ~fifo_empty[i];
            req_pin = ~dma_request_pin_n[i] & HS_CH_MASK[i];
            st_nxt.run[i] = c[B_DEN];
            st_nxt.c_auto[i] = c[B_DEN] & c[B_CHAINING_ENABLE];
            st_nxt.c_ins[i] = ~c[B_DEN] & c[B_CHAINING_ENABLE];
            st_nxt.tx[i] = c[B_TRAN];
            if (c[B_KIND]) begin
                st_nxt.ww[i] = WW_48;
            end else begin
                st_nxt.ww[i] = internal_word_width ? WW_40 : WW_32;
            end
            st_nxt.pm[i] = c[B_PM_LO +: 2];
            st_nxt.upper[i] = c[B_UPPER] & (c[B_PM_LO +: 2] != PM_32_48);
            st_nxt.irq[i] = ~c[B_DEN] & c[B_IRQ] & rdy;
            st_nxt.fill_req[i] = c[B_DEN] & c[B_TRAN] & ~fifo_full[i] & ~st_r.flush_p2[i];

            st_nxt.sreq[i] = 1'b0;
            st_nxt.mxfer[i] = 1'b0;
            st_nxt.paced[i] = 1'b0;
            st_nxt.x2x[i] = 1'b0;
            st_nxt.grant_n[i] = 1'b1;
            st_nxt.rsvd[i] = 1'b0;
            case (md)
                EPD_SLAVE: begin
                    st_nxt.sreq[i] = c[B_DEN] & rdy;
                end
                EPD_REQUEST_PACED: begin
                    st_nxt.grant_n[i] = ~(c[B_DEN] & req_pin & rdy);
                end
                EPD_EXT_HS: begin
                    st_nxt.grant_n[i] = ~(c[B_DEN] & req_pin & rdy);
                    st_nxt.x2x[i] = c[B_DEN];
                end
                EPD_MASTER: begin
                    st_nxt.mxfer[i] = c[B_DEN] & rdy & dma_count_nz[i];
                end
                EPD_PACED: begin
                    st_nxt.mxfer[i] = c[B_DEN] & req_pin & rdy & dma_count_nz[i];
                    st_nxt.paced[i] = c[B_DEN];
                end
                default: begin
                    st_nxt.rsvd[i] = 1'b1;
                end
            endcase
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge mclk) begin
        if (reset) begin
            // all clear but grant pins held high, channel 6 reloads next
            st_r <= '0;
            st_r.ctrl <= {NCH{CTRL_RST}};
            st_r.boot_pend <= 1'b1;
            st_r.grant_n <= '1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // outputs
    assign wb_dat_o = st_r.rdata;
    assign wb_ack_o = st_r.ack;
    assign fifo_flush = st_r.flush_p2;
    assign mem_fill_req = st_r.fill_req;
    assign dma_run = st_r.run;
    assign chain_auto = st_r.c_auto;
    assign chain_insert = st_r.c_ins;
    assign dir_tx = st_r.tx;
    assign mem_word_sel = st_r.ww;
    assign packing_select = st_r.pm;
    assign upper_half_first = st_r.upper;
    assign mode_reserved = st_r.rsvd;
    assign per_word_irq = st_r.irq;
    assign slave_req = st_r.sreq;
    assign master_xfer = st_r.mxfer;
    assign strobe_paced = st_r.paced;
    assign ext_to_ext = st_r.x2x;
    assign dma_grant_pin_n = st_r.grant_n;

endmodule : epd_ctrl

//--- epd_monitor.sv
/*
 * port assertions for the external port dma control block.
 * assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module epd_monitor
    import epd_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // register bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // fifo and pins
    input wire logic [NCH-1:0] dma_count_nz,
    input wire logic [NCH-1:0] fifo_full,
    input wire logic [NCH-1:0] dma_request_pin_n,
    input wire logic [NCH-1:0] dma_grant_pin_n,
    // channel outputs
    input wire logic [NCH-1:0] fifo_flush,
    input wire logic [NCH-1:0] mem_fill_req,
    input wire logic [NCH-1:0] dma_run,
    input wire logic [NCH-1:0] dir_tx,
    input wire logic [NCH-1:0] mode_reserved,
    input wire logic [NCH-1:0] per_word_irq,
    input wire logic [NCH-1:0] slave_req,
    input wire logic [NCH-1:0] master_xfer,
    input wire logic [NCH-1:0] strobe_paced
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    logic flush_wr;
    // ==========
    // flush write seen on the bus
    assign flush_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_dat_i[B_FLUSH] & (wb_adr_i[7:4] == 4'h7);
    AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
    AST_RD_ZERO: assert property (wb_ack_o && !wb_we_i |-> {wb_dat_o[31:16], wb_dat_o[B_FLUSH]} == 17'h0_0000)
        else $error("rd");
    AST_RUN_GATE: assert property (((slave_req | master_xfer | strobe_paced) & ~dma_run) == 4'h0) else $error("run");
    AST_IRQ_OFF: assert property ((per_word_irq & dma_run) == 4'h0) else $error("irq");
    AST_COUNT: assert property ((master_xfer & ~$past(dma_count_nz)) == 4'h0) else $error("count");
    AST_FILL: assert property ((mem_fill_req & ~(dir_tx & dma_run & ~$past(fifo_full))) == 4'h0) else $error("fill");
    AST_RSVD: assert property ((mode_reserved & (slave_req | master_xfer | strobe_paced)) == 4'h0) else $error("rsvd");
    AST_HS_CH: assert property (dma_grant_pin_n[0] && dma_grant_pin_n[3]) else $error("grant ch");
    AST_GRANT_PIN: assert property ((~dma_grant_pin_n & $past(dma_request_pin_n)) == 4'h0) else $error("grant");
    AST_FLUSH_ONE: assert property (fifo_flush != 4'h0 |=> fifo_flush == 4'h0) else $error("flush long");
    AST_FLUSH_LAT: assert property (flush_wr |-> ##[1:3] fifo_flush != 4'h0) else $error("flush late");
    COV_SLAVE: cover property (slave_req != 4'h0);
    COV_GRANT: cover property (dma_grant_pin_n != 4'hf);
    COV_FLUSH: cover property (fifo_flush != 4'h0);
endmodule : epd_monitor

bind epd_ctrl epd_monitor u_mon (.mclk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .dma_count_nz, .fifo_full, .dma_request_pin_n, .dma_grant_pin_n, .fifo_flush, .mem_fill_req,
    .dma_run, .dir_tx, .mode_reserved, .per_word_irq, .slave_req, .master_xfer, .strobe_paced);

//--- epd_far_model.sv
/*
 * far-side model: an external device driving the request pins.
 * assumes the bench says which channels want service.
 */
`timescale 1ns/1ps
module epd_far_model
    import epd_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // bench control
    input wire logic [NCH-1:0] want,
    input wire logic [NCH-1:0] in_master,
    // pins
    input wire logic [NCH-1:0] dma_grant_pin_n,
    output logic [NCH-1:0] dma_request_pin_n
);
    logic [NCH-1:0] req_r;
    // ==========
    // request pins, pulled high when idle
    always_ff @(posedge mclk) begin
        if (reset) begin
            req_r <= 4'h0;
        end else begin
            // drop when granted, idle in master
            req_r <= want & ~in_master & ~(req_r & ~dma_grant_pin_n);
        end
    end
    assign dma_request_pin_n = ~req_r;
endmodule : epd_far_model

//--- testbench.sv
/*
 * self-checking bench for the external port dma control block.
 * assumes package, design, far-side model and monitor compiled first.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module testbench;
    import epd_pkg::*;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, internal_word_width = 1'b0, rdy;
    logic [7:0] wb_adr_i = 8'h00, mem_word_sel, packing_select;
    logic [3:0] wb_sel_i = 4'h0, fifo_empty = 4'hf, fifo_full = 4'h0, ext_word = 4'h0, dma_count_nz = 4'h0;
    logic [3:0] want = 4'h0, in_master = 4'h0, dma_request_pin_n, dma_grant_pin_n, fifo_flush, mem_fill_req;
    logic [3:0] dma_run, chain_auto, chain_insert, dir_tx, upper_half_first, mode_reserved, per_word_irq;
    logic [3:0] slave_req, master_xfer, strobe_paced, ext_to_ext;
    logic [15:0] boot_ctrl = 16'h0000;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, d, sb_e;
    logic [31:0] exp_q[$];
    logic [2:0] m;
    integer seed = 32'ha12e_5085;
    int errors = 0, n_checks = 0, ch, k;
    epd_ctrl DUT (.mclk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
        .wb_ack_o, .boot_ctrl, .internal_word_width, .fifo_empty, .fifo_full, .ext_word, .dma_count_nz,
        .fifo_flush, .mem_fill_req, .dma_run, .chain_auto, .chain_insert, .dir_tx, .mem_word_sel,
        .packing_select, .upper_half_first, .mode_reserved, .per_word_irq, .slave_req, .master_xfer,
        .strobe_paced, .ext_to_ext, .dma_request_pin_n, .dma_grant_pin_n);
    epd_far_model u_far (.mclk, .reset, .want, .in_master, .dma_grant_pin_n, .dma_request_pin_n);
    always #2.5 mclk = ~mclk;
    // ==========
    // tasks
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report
    task automatic bound(input int n);
        if (n >= 40) begin
            $display("[FAIL] wait expected done seen timeout");
            errors++;
            final_report();
        end
    endtask : bound
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] v);
        int n;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= v;
        wb_sel_i <= 4'hf;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 40);
        bound(n);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge mclk);
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        wb(1'b0, a, 32'h0000_0000);
    endtask : rd
    function automatic logic [7:0] adr(input int c);
        return 8'h70 + 8'(c * 4);
    endfunction : adr
    task automatic cfg(input int c, input logic [15:0] v);
        m = {v[B_MASTER], v[B_PACED], v[B_EXTERN]};
        `CHK("run", v[B_DEN], dma_run[c])
        `CHK("auto", v[B_DEN] & v[B_CHAINING_ENABLE], chain_auto[c])
        `CHK("insert", ~v[B_DEN] & v[B_CHAINING_ENABLE], chain_insert[c])
        `CHK("dir", v[B_TRAN], dir_tx[c])
        `CHK("word", v[B_KIND] ? WW_48 : (internal_word_width ? WW_40 : WW_32), mem_word_sel[2*c +: 2])
        `CHK("pack", v[7:6], packing_select[2*c +: 2])
        `CHK("order", v[B_UPPER] && v[7:6] != PM_32_48, upper_half_first[c])
        `CHK("rsvd", m == 3'h1 || m == 3'h5 || m == 3'h7, mode_reserved[c])
    endtask : cfg
    // ==========
    // read scoreboard
    always @(posedge mclk) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
            sb_e = exp_q.pop_front();
            `CHK("read", sb_e, wb_dat_o)
        end
    end
    initial begin
        repeat (20000) @(posedge mclk);
        $display("[FAIL] run expected end seen timeout");
        errors++;
        final_report();
    end
    // ==========
    // main sequence
    initial begin
        boot_ctrl <= 16'($random(seed));
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        repeat (3) @(posedge mclk);
        rd(adr(0), {16'h0000, boot_ctrl & WR_MASK});
        for (int i = 1; i < NCH; i++) rd(adr(i), 32'h0000_0000);
        rd(8'h40, 32'h0000_0000);
        $display("test reset done");
        for (int n = 0; n < 16; n++) begin
            ch = n % NCH;
            d = $random(seed);
            d[B_FLUSH] = 1'b0;
            internal_word_width <= 1'($random(seed));
            wb(1'b1, adr(ch), d);
            rd(adr(ch), {16'h0000, d[15:0] & WR_MASK});
            cfg(ch, d[15:0]);
        end
        $display("test registers done");
        for (int n = 0; n < 32; n++) begin
            ch = n % NCH;
            m = 3'(n / NCH);
            d = $random(seed) & 32'h0000_0805;
            {d[B_MASTER], d[B_PACED], d[B_EXTERN]} = m;
            k = $unsigned($random(seed)) % 3;
            fifo_empty[ch] <= (k == 0);
            fifo_full[ch] <= (k == 2);
            dma_count_nz[ch] <= 1'($random(seed));
            in_master[ch] <= (m == 3'h4);
            wb(1'b1, adr(ch), d);
            repeat (2) @(posedge mclk);
            rdy = d[B_TRAN] ? (k != 2) : (k != 0);
            `CHK("slave", m == 3'h0 && d[B_DEN] && rdy, slave_req[ch])
            `CHK("master", m == 3'h4 && d[B_DEN] && rdy && dma_count_nz[ch], master_xfer[ch])
            `CHK("paced", m == 3'h6 && d[B_DEN], strobe_paced[ch])
            `CHK("irq", !d[B_DEN] && d[B_IRQ] && rdy, per_word_irq[ch])
            `CHK("fill", d[B_DEN] && d[B_TRAN] && k != 2, mem_fill_req[ch])
            if (d[B_DEN] && HS_CH_MASK[ch]) `CHK("ext", m == 3'h3, ext_to_ext[ch])
        end
        $display("test modes done");
        in_master <= 4'h0;
        fifo_empty <= 4'h0;
        fifo_full <= 4'h0;
        dma_count_nz <= 4'hf;
        wb(1'b1, adr(0), 32'h0000_0401);
        wb(1'b1, adr(1), 32'h0000_0401);
        wb(1'b1, adr(2), 32'h0000_0601);
        want <= 4'h7;
        k = 0;
        while ((dma_grant_pin_n[1] !== 1'b0 || master_xfer[2] !== 1'b1) && k < 40) begin
            @(posedge mclk);
            k++;
        end
        bound(k);
        `CHK("grant", 2'h2, {dma_grant_pin_n[0], dma_grant_pin_n[1]})
        `CHK("paced", 1'b1, master_xfer[2])
        want <= 4'h0;
        $display("test handshake done");
        fifo_full[3] <= 1'b1;
        // bench as host keeps its width matched to 16-bit packing
        wb(1'b1, adr(3), 32'h0000_0080);
        ext_word[3] <= 1'b1;
        @(posedge mclk);
        ext_word[3] <= 1'b0;
        rd(adr(3), 32'h0000_c088);
        fifo_full[3] <= 1'b0;
        repeat (2) @(posedge mclk);
        rd(adr(3), 32'h0000_8088);
        ext_word[3] <= 1'b1;
        @(posedge mclk);
        ext_word[3] <= 1'b0;
        rd(adr(3), 32'h0000_8090);
        wb(1'b1, adr(3), 32'h0000_2080);
        k = 0;
        while (fifo_flush[3] !== 1'b1 && k < 40) begin
            @(posedge mclk);
            k++;
        end
        bound(k);
        `CHK("flush", 1'b1, fifo_flush[3])
        fifo_empty[3] <= 1'b1;
        repeat (2) @(posedge mclk);
        rd(adr(3), 32'h0000_0080);
        repeat (2) @(posedge mclk);
        `CHK("queue", 0, exp_q.size())
        $display("test flush done");
        final_report();
    end
endmodule : testbench
